// ---- ppfc_pkg.sv ----
// constants shared by the process pid frequency controller files
// assumes a single 10 MHz ref_clk and 12-bit analog codes already digitised
`default_nettype none
package ppfc_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int ADC_W = 12;
  localparam int FREQ_W = 16;
  localparam int DIN_N = 5;
  localparam logic [ADC_W-1:0] FULL_SCALE = 12'hfff;
  // 4 mA on a 0..20 mA current input
  localparam logic [ADC_W-1:0] CUR_4MA = 12'h333;
  localparam logic [4:0] FUNC_REF_SEL = 5'h09;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_INVERSE = 2'h2;
  localparam logic [1:0] FB_VOLT_NORM = 2'h0;
  localparam logic [1:0] FB_CUR_NORM = 2'h1;
  localparam logic [1:0] FB_VOLT_INV = 2'h2;
  localparam logic [1:0] FB_CUR_INV = 2'h3;
  localparam logic [9:0] GAIN_MIN = 10'h001;
  localparam logic [9:0] GAIN_MAX = 10'h3e8;
  localparam logic [15:0] ITIME_MAX = 16'h8ca0;
  localparam logic [9:0] DTIME_MAX = 10'h3e8;
  localparam logic [9:0] FILT_MAX = 10'h258;
  localparam int GAIN_SCALE = 100;
  localparam int COEF_SCALE = 100;
  // control period in microseconds and its cycle count
  localparam int CTRL_PERIOD_US = 1000;
  localparam int CTRL_PERIOD_CYC = CTRL_PERIOD_US * (CLK_HZ / 1000000);
  // integral time counts 0.1 s, derivative time 0.01 s, both against the period
  localparam int I_DIV_PER_TENTH = 100000 / CTRL_PERIOD_US;
  localparam int D_MUL_PER_HUNDREDTH = 10000 / CTRL_PERIOD_US;
  // filter steps by 1/16 of the error, so a step lasts a sixteenth of the time constant
  localparam int FILT_SHIFT = 4;
  localparam int FILT_TENTH_MS = 100;
  localparam int FILT_CYC_PER_TENTH = (FILT_TENTH_MS * (CLK_HZ / 1000)) / (2 ** FILT_SHIFT);
  localparam int ISUM_W = 20;
  localparam logic signed [ISUM_W-1:0] ISUM_MAX = 20'h7ffff;
  localparam logic signed [ISUM_W-1:0] ISUM_MIN = 20'h80001;
endpackage
`default_nettype wire

// ---- ppfc_fb_if.sv ----
// carrier between the pid core and the feedback filter
// assumes both ends run on ref_clk
`default_nettype none
interface ppfc_fb_if;
  logic [11:0] raw;
  logic [9:0] tau;
  logic [11:0] filtered;
  modport filt (input raw, input tau, output filtered);
  modport ctrl (output raw, output tau, input filtered);
endinterface
`default_nettype wire

// ---- ppfc_fb_filter.sv ----
// first order low-pass on the feedback value
// assumes raw is already synchronised to ref_clk; tau counts 0.1 s
`default_nettype none
module ppfc_fb_filter #(
  parameter int unsigned CYC_PER_TENTH = ppfc_pkg::FILT_CYC_PER_TENTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  ppfc_fb_if.filt fb
);
  logic [15:0] acc_q, acc_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] limit_w;
  logic step_w;
  logic signed [16:0] diff_w;

  assign limit_w = 32'(fb.tau) * 32'(CYC_PER_TENTH);
  assign step_w = (cnt_q + 32'h1) >= limit_w;
  assign diff_w = $signed({1'b0, fb.raw, 4'h0}) - $signed({1'b0, acc_q});
  // a zero time constant passes the sample straight through
  assign cnt_d = (fb.tau == 10'h0 || step_w) ? 32'h0 : cnt_q + 32'h1;
  assign acc_d = (fb.tau == 10'h0) ? {fb.raw, 4'h0} :
                 step_w ? 16'(acc_q + 16'(diff_w >>> ppfc_pkg::FILT_SHIFT)) : acc_q; // see (RQ13)
  assign fb.filtered = acc_q[15:4];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      acc_q <= 16'h0;
      cnt_q <= 32'h0;
    end else begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ---- ppfc_pid_top.sv ----
// process pid controller producing the drive's output frequency
// assumes analog codes and digital inputs arrive from pins, settings from logic on ref_clk
`default_nettype none
// Function
// (RQ1) error is reference minus filtered feedback; output moves to shrink it
// (RQ2) mode selects forward or inverse sense of the controller output
// (RQ3) any of five digital terminals assigned code 9 selects the reference source
// (RQ4) selector off takes primary frequency command, on takes keypad reference
// (RQ5) feedback code 0 voltage normal, code 1 current 4-20 mA normal
// (RQ6) feedback code 2 voltage inverted, code 3 current 20-4 mA inverted
// (RQ7) feedback is unsigned; values below zero clip to zero
// (RQ8) proportional term is gain times error, gain 0.01 to 10.00
// (RQ9) integral time 0.1 to 3600 s accumulates error; zero disables it
// (RQ10) derivative time 0.01 to 10.0 s times error rate; zero disables it
// (RQ11) terms combine so P, PI, PD and PID all arise from settings
// (RQ12) reference and feedback scaled for display by two coefficients
// (RQ13) feedback low-pass filtered, time constant 0.0 to 60.0 s
// (RQ14) terms evaluated once per control period; output clamped to limits
// (RQ15) integral frozen while output is clamped in the error's direction
module ppfc_pid_top #(
  parameter int unsigned PERIOD_CYC = ppfc_pkg::CTRL_PERIOD_CYC,
  parameter int unsigned FILT_CYC = ppfc_pkg::FILT_CYC_PER_TENTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [1:0] pid_mode_select,
  input wire logic [1:0] pid_feedback_select,
  input wire logic [9:0] pid_proportional_gain,
  input wire logic [15:0] pid_integral_time,
  input wire logic [9:0] pid_derivative_time,
  input wire logic [9:0] pid_feedback_filter,
  input wire logic [11:0] primary_frequency_command,
  input wire logic [11:0] keypad_reference,
  input wire logic [4:0] first_digital_input_function,
  input wire logic [4:0] second_digital_input_function,
  input wire logic [4:0] third_digital_input_function,
  input wire logic [4:0] fourth_digital_input_function,
  input wire logic [4:0] fifth_digital_input_function,
  input wire logic [4:0] digital_input_pins,
  input wire logic [11:0] voltage_analog_input,
  input wire logic [11:0] current_analog_input,
  input wire logic [15:0] display_coefficient_first,
  input wire logic [15:0] display_coefficient_second,
  input wire logic [15:0] freq_upper_limit,
  input wire logic [15:0] freq_lower_limit,
  output logic [15:0] output_frequency,
  output logic [15:0] reference_display,
  output logic [15:0] feedback_display,
  output logic keypad_ref_selected,
  output logic output_clamped
);
  function automatic logic is_ref_sel(input logic [4:0] code);
    return code == ppfc_pkg::FUNC_REF_SEL;
  endfunction

  function automatic logic [15:0] sat16(input logic [27:0] v);
    return (v[27:16] != 12'h0) ? 16'hffff : v[15:0];
  endfunction

  // pin synchronisers; the first stage feeds only the second
  logic [4:0] din_s1_q, din_s2_q;
  logic [11:0] volt_s1_q, volt_s2_q, cur_s1_q, cur_s2_q;

  logic [4:0] din_func_w [ppfc_pkg::DIN_N];
  logic [4:0] sel_hit_w;
  logic ref_sel_w;
  logic [11:0] ref_w;
  logic [13:0] cur_scaled_w;
  logic [11:0] cur_lin_w, fb_lin_w, fb_raw_w, fb_filt_w;
  logic inverse_fb_w;

  logic [9:0] kp_w, td_w, tau_w;
  logic [15:0] ti_w;

  logic [31:0] per_cnt_q, per_cnt_d;
  logic tick_w;

  logic signed [12:0] err_raw_w, err_w, err_prev_q;
  logic signed [13:0] derr_w;
  logic signed [31:0] dterm_w, sum_w;
  logic signed [47:0] prod_w, u_w;
  logic hi_w, lo_w;
  logic [15:0] u_clamp_w, freq_d;

  logic signed [25:0] frac_q, frac_d, lim_w;
  logic signed [ppfc_pkg::ISUM_W-1:0] isum_q, isum_d;
  logic frac_pos_w, frac_neg_w, windup_w, hold_q;

  logic [15:0] freq_q, ref_disp_q, fb_disp_q;
  logic ref_sel_q, clamped_q;

  ppfc_fb_if fb_bus();

  assign din_func_w[0] = first_digital_input_function;
  assign din_func_w[1] = second_digital_input_function;
  assign din_func_w[2] = third_digital_input_function;
  assign din_func_w[3] = fourth_digital_input_function;
  assign din_func_w[4] = fifth_digital_input_function;

  for (genvar i = 0; i < ppfc_pkg::DIN_N; i++) begin : g_sel
    assign sel_hit_w[i] = is_ref_sel(din_func_w[i]) && din_s2_q[i]; // see (RQ3)
  end
  assign ref_sel_w = |sel_hit_w;
  assign ref_w = ref_sel_w ? keypad_reference : primary_frequency_command; // see (RQ4)

  // current input: 4 mA maps to zero, 20 mA to full scale; below 4 mA clips at zero
  assign cur_scaled_w = (cur_s2_q <= ppfc_pkg::CUR_4MA) ? 14'h0 :
                        14'((14'(cur_s2_q - ppfc_pkg::CUR_4MA) * 14'h5) >> 2); // see (RQ7)
  assign cur_lin_w = (cur_scaled_w > 14'(ppfc_pkg::FULL_SCALE)) ? ppfc_pkg::FULL_SCALE : cur_scaled_w[11:0];
  assign inverse_fb_w = (pid_feedback_select == ppfc_pkg::FB_VOLT_INV) ||
                        (pid_feedback_select == ppfc_pkg::FB_CUR_INV);
  assign fb_lin_w = (pid_feedback_select == ppfc_pkg::FB_CUR_NORM ||
                     pid_feedback_select == ppfc_pkg::FB_CUR_INV) ? cur_lin_w : volt_s2_q; // see (RQ5)
  assign fb_raw_w = inverse_fb_w ? ppfc_pkg::FULL_SCALE - fb_lin_w : fb_lin_w; // see (RQ6)

  // settings out of range are pulled to the nearest legal value
  assign kp_w = (pid_proportional_gain < ppfc_pkg::GAIN_MIN) ? ppfc_pkg::GAIN_MIN :
                (pid_proportional_gain > ppfc_pkg::GAIN_MAX) ? ppfc_pkg::GAIN_MAX : pid_proportional_gain;
  assign ti_w = (pid_integral_time > ppfc_pkg::ITIME_MAX) ? ppfc_pkg::ITIME_MAX : pid_integral_time;
  assign td_w = (pid_derivative_time > ppfc_pkg::DTIME_MAX) ? ppfc_pkg::DTIME_MAX : pid_derivative_time;
  assign tau_w = (pid_feedback_filter > ppfc_pkg::FILT_MAX) ? ppfc_pkg::FILT_MAX : pid_feedback_filter;

  assign fb_bus.raw = fb_raw_w;
  assign fb_bus.tau = tau_w;
  assign fb_filt_w = fb_bus.filtered;

  ppfc_fb_filter #(.CYC_PER_TENTH(FILT_CYC)) u_filter ( // see (RQ13)
    .ref_clk(ref_clk),
    .srst(srst),
    .fb(fb_bus.filt)
  );

  assign tick_w = per_cnt_q >= (PERIOD_CYC - 32'h1); // see (RQ14)
  assign per_cnt_d = tick_w ? 32'h0 : per_cnt_q + 32'h1;

  assign err_raw_w = $signed({1'b0, ref_w}) - $signed({1'b0, fb_filt_w}); // see (RQ1)
  assign err_w = (pid_mode_select == ppfc_pkg::MODE_INVERSE) ? -err_raw_w : err_raw_w; // see (RQ2)

  // derivative over one period; zero time gives zero term
  assign derr_w = 14'(err_w) - 14'(err_prev_q);
  assign dterm_w = 32'(derr_w) * $signed({22'h0, td_w}) * ppfc_pkg::D_MUL_PER_HUNDREDTH; // see (RQ10)

  // integral divided serially: one count leaves frac per clock, far faster than the period needs
  assign lim_w = $signed(26'(32'(ti_w) * ppfc_pkg::I_DIV_PER_TENTH));
  assign frac_pos_w = (ti_w != 16'h0) && (frac_q >= lim_w) && (isum_q != ppfc_pkg::ISUM_MAX);
  assign frac_neg_w = (ti_w != 16'h0) && (frac_q <= -lim_w) && (isum_q != ppfc_pkg::ISUM_MIN);
  assign windup_w = hold_q && (clamped_q ? 1'b1 : 1'b0); // see (RQ15)
  always_comb begin
    frac_d = frac_q;
    isum_d = isum_q;
    if (ti_w == 16'h0 || pid_mode_select == ppfc_pkg::MODE_OFF) begin
      frac_d = 26'sh0; // see (RQ9)
      isum_d = '0;
    end else begin
      if (frac_pos_w) begin
        frac_d = frac_d - lim_w;
        isum_d = isum_d + 20'sh1;
      end else if (frac_neg_w) begin
        frac_d = frac_d + lim_w;
        isum_d = isum_d - 20'sh1;
      end
      if (tick_w && !windup_w) begin
        frac_d = frac_d + 26'(err_w); // see (RQ9)
      end
    end
  end

  assign sum_w = 32'(err_w) + 32'(isum_q) + dterm_w; // see (RQ11)
  assign prod_w = 48'(sum_w) * $signed({38'h0, kp_w}); // see (RQ8)
  assign u_w = prod_w / ppfc_pkg::GAIN_SCALE;
  assign hi_w = u_w > $signed({32'h0, freq_upper_limit});
  assign lo_w = u_w < $signed({32'h0, freq_lower_limit});
  assign u_clamp_w = hi_w ? freq_upper_limit : lo_w ? freq_lower_limit : u_w[15:0]; // see (RQ14)
  assign freq_d = (pid_mode_select == ppfc_pkg::MODE_OFF) ? {4'h0, primary_frequency_command} : u_clamp_w;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      din_s1_q <= 5'h0;
      din_s2_q <= 5'h0;
      volt_s1_q <= 12'h0;
      volt_s2_q <= 12'h0;
      cur_s1_q <= 12'h0;
      cur_s2_q <= 12'h0;
    end else begin
      din_s1_q <= digital_input_pins;
      din_s2_q <= din_s1_q;
      volt_s1_q <= voltage_analog_input;
      volt_s2_q <= volt_s1_q;
      cur_s1_q <= current_analog_input;
      cur_s2_q <= cur_s1_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      per_cnt_q <= 32'h0;
      frac_q <= 26'sh0;
      isum_q <= '0;
    end else begin
      per_cnt_q <= per_cnt_d;
      frac_q <= frac_d;
      isum_q <= isum_d;
    end
  end

  // hold remembers whether the last clamp pushed the same way as the error of that same tick
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      err_prev_q <= 13'sh0;
      freq_q <= 16'h0;
      clamped_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (tick_w) begin
      err_prev_q <= err_w;
      freq_q <= freq_d; // see (RQ14)
      clamped_q <= (hi_w || lo_w) && (pid_mode_select != ppfc_pkg::MODE_OFF);
      hold_q <= (hi_w && err_w > 13'sh0) || (lo_w && err_w < 13'sh0); // see (RQ15)
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ref_disp_q <= 16'h0;
      fb_disp_q <= 16'h0;
      ref_sel_q <= 1'b0;
    end else begin
      ref_disp_q <= sat16(28'(({16'h0, ref_w} * {12'h0, display_coefficient_first}) / ppfc_pkg::COEF_SCALE)); // see (RQ12)
      fb_disp_q <= sat16(28'(({16'h0, fb_filt_w} * {12'h0, display_coefficient_second}) / ppfc_pkg::COEF_SCALE));
      ref_sel_q <= ref_sel_w;
    end
  end

  assign output_frequency = freq_q;
  assign reference_display = ref_disp_q;
  assign feedback_display = fb_disp_q;
  assign keypad_ref_selected = ref_sel_q;
  assign output_clamped = clamped_q;
endmodule
`default_nettype wire

// ---- ppfc_pid_checker.sv ----
// concurrent checks on the pid controller's top ports
// assumes binding into ppfc_pid_top; tick mirrors the control period counter
`default_nettype none
module ppfc_pid_checker #(
  parameter int unsigned PERIOD_CYC = 20
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [1:0] pid_mode_select,
  input wire logic [11:0] primary_frequency_command,
  input wire logic [11:0] keypad_reference,
  input wire logic [15:0] display_coefficient_first,
  input wire logic [15:0] freq_upper_limit,
  input wire logic [15:0] freq_lower_limit,
  input wire logic [15:0] output_frequency,
  input wire logic [15:0] reference_display,
  input wire logic [15:0] feedback_display,
  input wire logic keypad_ref_selected,
  input wire logic output_clamped
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cnt_q;
  logic tick;
  assign tick = cnt_q == 32'(PERIOD_CYC - 1);
  always_ff @(posedge ref_clk)
    cnt_q <= (srst || tick) ? 32'h0 : cnt_q + 32'h1;
  function automatic logic [15:0] disp(input logic [11:0] v, input logic [15:0] c);
    int p;
    p = int'(v) * int'(c) / ppfc_pkg::COEF_SCALE;
    return p > 32'hffff ? 16'hffff : 16'(p);
  endfunction
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  property p_reset;
    disable iff (1'b0) srst |=> output_frequency == 16'h0 && reference_display == 16'h0
      && feedback_display == 16'h0 && !keypad_ref_selected && !output_clamped;
  endproperty
  property p_out_hold;
    !tick |=> $stable(output_frequency);
  endproperty
  property p_flag_hold;
    !tick |=> $stable(output_clamped);
  endproperty
  property p_range;
    tick && pid_mode_select != 2'h0 && freq_upper_limit >= freq_lower_limit |=>
      output_frequency <= $past(freq_upper_limit) && output_frequency >= $past(freq_lower_limit);
  endproperty
  property p_off_val;
    tick && pid_mode_select == 2'h0 |=> output_frequency == {4'h0, $past(primary_frequency_command)};
  endproperty
  property p_off_flag;
    tick && pid_mode_select == 2'h0 |=> !output_clamped;
  endproperty
  property p_at_limit;
    tick ##1 output_clamped |->
      output_frequency == $past(freq_upper_limit) || output_frequency == $past(freq_lower_limit);
  endproperty
  property p_refdisp;
    // the display register and the selector flag load on the same edge, so the flag seen then picks the source
    $stable(keypad_ref_selected) |=> reference_display == disp(keypad_ref_selected ?
      $past(keypad_reference) : $past(primary_frequency_command), $past(display_coefficient_first));
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  a_out_hold: assert property (p_out_hold) else $error("output moved off tick");
  a_flag_hold: assert property (p_flag_hold) else $error("clamp flag moved off tick");
  a_range: assert property (p_range) else $error("output outside limits");
  a_off_val: assert property (p_off_val) else $error("mode off not passing command");
  a_off_flag: assert property (p_off_flag) else $error("clamp flag in mode off");
  a_at_limit: assert property (p_at_limit) else $error("clamped but not at a limit");
  a_refdisp: assert property (p_refdisp) else $error("reference display wrong");
  c_clamped: cover property (tick ##1 output_clamped);
  c_keypad: cover property ($rose(keypad_ref_selected));
  c_off: cover property (tick && pid_mode_select == 2'h0);
endmodule
bind ppfc_pid_top ppfc_pid_checker #(.PERIOD_CYC(PERIOD_CYC)) u_chk (.*);
`default_nettype wire

// ---- ppfc_sensor_model.sv ----
// process sensor adc and frequency command source for the pid controller
// assumes the bench sets the process level and command code
`default_nettype none
module ppfc_sensor_model (
  input wire logic ref_clk,
  input wire logic [11:0] level,
  input wire logic [11:0] cmd,
  output logic [11:0] voltage_analog_input,
  output logic [11:0] current_analog_input,
  output logic [11:0] primary_frequency_command
);
  timeunit 1ns;
  timeprecision 1ns;
  // codes only ever positive, never a signed reading; unknown until the first edge, which reset covers
  // the adc holds each conversion a full cycle, as the bus synchroniser needs
  always @(posedge ref_clk) begin
    voltage_analog_input <= level;
    current_analog_input <= level;
    primary_frequency_command <= cmd;
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the pid controller with a short control period
// assumes ppfc_pkg, the design files, the sensor model and the checker
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 20;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] pid_mode_select = 2'h1, pid_feedback_select = 2'h0;
  logic [9:0] pid_proportional_gain = 10'h64, pid_derivative_time = 10'h0, pid_feedback_filter = 10'h0;
  logic [15:0] pid_integral_time = 16'h0, display_coefficient_first = 16'h64, display_coefficient_second = 16'h64;
  logic [15:0] freq_upper_limit = 16'hffff, freq_lower_limit = 16'h0, v0;
  logic [11:0] keypad_reference = 12'h0, level = 12'h0, cmd = 12'h0;
  logic [4:0] digital_input_pins = 5'h0;
  logic [4:0] fn [5] = '{5'h0, 5'h0, 5'h0, 5'h0, 5'h0};
  wire logic [4:0] first_digital_input_function = fn[0];
  wire logic [4:0] second_digital_input_function = fn[1];
  wire logic [4:0] third_digital_input_function = fn[2];
  wire logic [4:0] fourth_digital_input_function = fn[3];
  wire logic [4:0] fifth_digital_input_function = fn[4];
  logic [11:0] primary_frequency_command, voltage_analog_input, current_analog_input;
  logic [15:0] output_frequency, reference_display, feedback_display;
  logic keypad_ref_selected, output_clamped, sel;
  logic [16:0] w;
  logic [31:0] seed = 32'h57;
  int mismatches = 0, n_checks = 0, cnt = 0;
  ppfc_sensor_model sens (.*);
  ppfc_pid_top #(.PERIOD_CYC(P), .FILT_CYC(4)) dut (.*);
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    cnt <= (srst || cnt == P - 1) ? 0 : cnt + 1;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int fbv();
    int v;
    v = int'(level);
    if (pid_feedback_select[0])
      v = v <= int'(ppfc_pkg::CUR_4MA) ? 0 : (v - int'(ppfc_pkg::CUR_4MA)) * 5 / 4;
    if (v > int'(ppfc_pkg::FULL_SCALE))
      v = int'(ppfc_pkg::FULL_SCALE);
    if (pid_feedback_select[1])
      v = int'(ppfc_pkg::FULL_SCALE) - v;
    return v;
  endfunction
  function automatic logic [15:0] disp(input int v, input logic [15:0] c);
    int p;
    p = v * int'(c) / ppfc_pkg::COEF_SCALE;
    return p > 32'hffff ? 16'hffff : 16'(p);
  endfunction
  // proportional-only expectation with {clamped, output}
  function automatic logic [16:0] want(input logic [11:0] r);
    int e;
    int u;
    e = int'(r) - fbv();
    if (pid_mode_select == ppfc_pkg::MODE_INVERSE)
      e = -e;
    u = e * int'(pid_proportional_gain) / ppfc_pkg::GAIN_SCALE;
    if (pid_mode_select == ppfc_pkg::MODE_OFF)
      return {5'h0, cmd};
    if (u > int'(freq_upper_limit))
      return {1'b1, freq_upper_limit};
    if (u < int'(freq_lower_limit))
      return {1'b1, freq_lower_limit};
    return {1'b0, 16'(u)};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // returns in the time step of a control tick edge, before its updates land
  task automatic tick();
    @(posedge ref_clk);
    while (cnt != P - 1) @(posedge ref_clk);
  endtask
  task automatic results();
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // about 5000 cycles are needed; allow four times that
  initial begin
    #2000000;
    mismatches++;
    results();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      tick();
      pid_mode_select <= 2'(i % 4);
      pid_feedback_select <= 2'(i / 4 % 4);
      pid_proportional_gain <= 10'(xs() % 1000 + 1);
      level <= 12'(xs());
      cmd <= 12'(xs());
      keypad_reference <= 12'(xs());
      freq_lower_limit <= 16'(xs() % 2048);
      freq_upper_limit <= 16'(xs() % 8192);
      display_coefficient_first <= 16'(xs());
      display_coefficient_second <= 16'(xs());
      digital_input_pins <= 5'(xs());
      foreach (fn[k]) fn[k] <= (k == i % 5) ? ppfc_pkg::FUNC_REF_SEL : 5'(xs() % 9);
      tick();
      tick();
      #1;
      sel = digital_input_pins[i % 5];
      w = want(sel ? keypad_reference : cmd);
      chk_flag(keypad_ref_selected, sel);
      chk(output_frequency, w[15:0]);
      chk_flag(output_clamped, w[16]);
      chk(feedback_display, disp(fbv(), display_coefficient_second));
      chk(reference_display, disp(int'(sel ? keypad_reference : cmd), display_coefficient_first));
    end
    tick();
    pid_mode_select <= 2'h1;
    pid_feedback_select <= 2'h0;
    pid_proportional_gain <= 10'h64;
    pid_derivative_time <= 10'h1;
    freq_upper_limit <= 16'hffff;
    freq_lower_limit <= 16'h0;
    display_coefficient_second <= 16'h64;
    digital_input_pins <= 5'h0;
    level <= 12'h100;
    cmd <= 12'h300;
    tick();
    tick();
    cmd <= 12'h400;
    tick();
    #1;
    chk(output_frequency, 16'hd00);
    tick();
    #1;
    chk(output_frequency, 16'h300);
    tick();
    pid_derivative_time <= 10'h0;
    pid_integral_time <= 16'h1;
    cmd <= 12'h300;
    repeat (10) tick();
    #1;
    v0 = output_frequency;
    chk_flag(v0 > 16'h210, 1'b1);
    tick();
    freq_upper_limit <= 16'h201;
    repeat (20) tick();
    #1;
    chk(output_frequency, 16'h201);
    chk_flag(output_clamped, 1'b1);
    tick();
    freq_upper_limit <= 16'hffff;
    tick();
    tick();
    #1;
    chk_flag(output_frequency < v0 + 16'h20, 1'b1);
    tick();
    pid_integral_time <= 16'h0;
    level <= 12'h0;
    tick();
    tick();
    pid_feedback_filter <= 10'h1;
    level <= 12'hfff;
    repeat (40) @(posedge ref_clk);
    #1;
    chk_flag(feedback_display > 16'h0 && feedback_display < 16'hfff, 1'b1);
    repeat (1600) @(posedge ref_clk);
    #1;
    chk_flag(feedback_display >= 16'hffe, 1'b1);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(output_frequency, 16'h0);
    chk(feedback_display, 16'h0);
    @(posedge ref_clk);
    srst <= 1'b0;
    results();
  end
endmodule
`default_nettype wire
